//--- rtl/irqv_top.sv
`timescale 1ns/1ps
module irqv_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [irqv_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [irqv_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [irqv_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [5:0] ext_pin_n,
  input wire logic [2:0] timer_ovf,
  input wire logic [1:0] serial0_evt,
  input wire logic [1:0] serial1_evt,
  input wire logic watchdog_evt,
  input wire logic [7:0] aux_evt,
  input wire logic instr_done,
  input wire logic vector_ack,
  input wire logic reti_done,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output irqv_pkg::irqv_lvl_t irq_level,
  output logic irq_out
);
  import irqv_pkg::*;

  logic rst_sync_n, aux_group_enable, global_irq_enable, ack_now, wr_ext_ctrl;
  logic hi_found, lo_found, act_aux, act_hi, act_lo, can_aux, can_hi, can_lo;
  logic [1:0] ext_edge_mode, evt_stat, evt_mask;
  logic [3:0] hi_idx, lo_idx, next_src, offer_src;
  logic [4:0] ext_enable_reg2, ext_priority_reg2;
  logic [5:0] pin_q, pin_prev, pin_fall;
  logic [6:0] irq_priority_reg;
  logic [7:0] irq_enable_reg, aux_enable_reg;
  logic [11:0] hi_req, lo_req;
  logic [12:0] pend, en_vec, req_en, hw_set, hw_clr, sw_hit, sw_val;
  logic [12:0] lvl_follow, pin_lvl, below_src;
  irqv_lvl_t next_lvl;
  irqv_state_t state;

  irqv_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(1'b1),
    .q(rst_sync_n)
  );

  irqv_sync #(.W(6), .RST_VAL(PIN_IDLE)) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .d(ext_pin_n),
    .q(pin_q)
  );

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_prev <= PIN_IDLE;
    end else begin
      pin_prev <= pin_q;
    end
  end

  assign pin_fall = pin_prev & ~pin_q;
  assign wr_ext_ctrl = reg_wr && (reg_addr == REG_EXT_CTRL);

  // configuration registers, all enables cleared at reset
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_enable_reg <= RST_REG;
      ext_enable_reg2 <= RST_REG[4:0];
      irq_priority_reg <= RST_REG[6:0];
      ext_priority_reg2 <= RST_REG[4:0];
      aux_group_enable <= 1'b0;
      ext_edge_mode <= RST_REG[1:0];
      aux_enable_reg <= RST_REG;
      evt_mask <= RST_REG[1:0];
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_IRQ_EN: irq_enable_reg <= reg_wdata;
        REG_EXT_EN2: ext_enable_reg2 <= reg_wdata[4:0];
        REG_IRQ_PRI: irq_priority_reg <= reg_wdata[6:0];
        REG_EXT_PRI2: ext_priority_reg2 <= reg_wdata[4:0];
        REG_EXT_CTRL: aux_group_enable <= reg_wdata[AUX_EN_BIT];
        REG_EXT_MODE: ext_edge_mode <= reg_wdata[1:0];
        REG_AUX_EN: aux_enable_reg <= reg_wdata;
        REG_EVT_MASK: evt_mask <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  assign global_irq_enable = irq_enable_reg[GLOBAL_EN_BIT];
  assign en_vec = {ext_enable_reg2, irq_enable_reg[6:0], aux_group_enable};
  assign req_en = pend & en_vec & {{12{global_irq_enable}}, 1'b1};
  assign hi_req = req_en[12:1] & {ext_priority_reg2, irq_priority_reg};
  assign lo_req = req_en[12:1] & ~{ext_priority_reg2, irq_priority_reg};

  always_comb begin
    hw_set = {watchdog_evt, pin_fall[5:2], |serial1_evt, timer_ovf[2], |serial0_evt,
              timer_ovf[1], pin_fall[1] & ext_edge_mode[1], timer_ovf[0],
              pin_fall[0] & ext_edge_mode[0], |(aux_evt & aux_enable_reg)};
    hw_clr = '0;
    if (ack_now) begin
      hw_clr = (13'h0001 << offer_src) & {8'h00, 1'b1, ext_edge_mode[1], 1'b1,
                                          ext_edge_mode[0], 1'b0};
    end
    sw_hit = {wr_ext_ctrl, {3{reg_wr && (reg_addr == REG_PEND_HI)}},
              {8{reg_wr && (reg_addr == REG_PEND_LO)}}, 1'b0};
    sw_val = {reg_wdata[WDT_FLAG_BIT], reg_wdata[2:0], reg_wdata, 1'b0};
    lvl_follow = {9'h000, ~ext_edge_mode[1], 1'b0, ~ext_edge_mode[0], 1'b0};
    pin_lvl = {9'h000, ~pin_q[1], 1'b0, ~pin_q[0], 1'b0};
  end

  // pending flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pend <= '0;
    end else begin
      if (hw_set[0]) begin
        pend[0] <= 1'b1;
      end else if (wr_ext_ctrl && !reg_wdata[AUX_FLAG_BIT]) begin
        pend[0] <= 1'b0;
      end
      for (int i = 1; i < N_SRC; i++) begin
        if (lvl_follow[i]) begin
          pend[i] <= pin_lvl[i];
        end else if (hw_set[i]) begin
          pend[i] <= 1'b1;
        end else if (hw_clr[i]) begin
          pend[i] <= 1'b0;
        end else if (sw_hit[i]) begin
          pend[i] <= sw_val[i];
        end
      end
    end
  end

  irqv_pick #(.N(12), .IW(4)) u_pick_hi (
    .req(hi_req),
    .found(hi_found),
    .idx(hi_idx)
  );

  irqv_pick #(.N(12), .IW(4)) u_pick_lo (
    .req(lo_req),
    .found(lo_found),
    .idx(lo_idx)
  );

  // nesting: aux blocks all, high blocks high and low, low blocks low
  assign can_aux = req_en[0] && !act_aux;
  assign can_hi = hi_found && !act_aux && !act_hi;
  assign can_lo = lo_found && !act_aux && !act_hi && !act_lo;

  always_comb begin
    next_src = SRC_AUX;
    next_lvl = LVL_NONE;
    if (can_aux) begin
      next_src = SRC_AUX;
      next_lvl = LVL_AUX;
    end else if (can_hi) begin
      next_src = 4'(hi_idx + 4'h1);
      next_lvl = LVL_HI;
    end else if (can_lo) begin
      next_src = 4'(lo_idx + 4'h1);
      next_lvl = LVL_LO;
    end
  end

  assign ack_now = (state == ST_OFFER) && vector_ack;

  // offer holds until the core acknowledges; decisions only at instruction end
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_IDLE;
      irq_req <= 1'b0;
      offer_src <= SRC_AUX;
      irq_vector <= RST_REG;
      irq_level <= LVL_NONE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (instr_done && next_lvl != LVL_NONE) begin
            state <= ST_OFFER;
            irq_req <= 1'b1;
            offer_src <= next_src;
            irq_vector <= irqv_vec_addr(next_src);
            irq_level <= next_lvl;
          end
        end
        ST_OFFER: begin
          if (vector_ack) begin
            state <= ST_IDLE;
            irq_req <= 1'b0;
            irq_level <= LVL_NONE;
          end
        end
      endcase
    end
  end

  // running handler levels; return ends the highest one
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      act_aux <= 1'b0;
      act_hi <= 1'b0;
      act_lo <= 1'b0;
    end else begin
      if (reti_done) begin
        if (act_aux) begin
          act_aux <= 1'b0;
        end else if (act_hi) begin
          act_hi <= 1'b0;
        end else begin
          act_lo <= 1'b0;
        end
      end
      if (ack_now) begin
        unique case (irq_level)
          LVL_AUX: act_aux <= 1'b1;
          LVL_HI: act_hi <= 1'b1;
          LVL_LO: act_lo <= 1'b1;
          LVL_NONE: ;
        endcase
      end
    end
  end

  // sticky events, write one to clear, a new event wins
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      evt_stat <= RST_REG[1:0];
    end else begin
      evt_stat[EVT_TAKEN_BIT] <= ack_now || (evt_stat[EVT_TAKEN_BIT] &&
        !(reg_wr && reg_addr == REG_EVT_STAT && reg_wdata[EVT_TAKEN_BIT]));
      evt_stat[EVT_NEST_BIT] <= (ack_now && (act_aux || act_hi || act_lo)) ||
        (evt_stat[EVT_NEST_BIT] &&
        !(reg_wr && reg_addr == REG_EVT_STAT && reg_wdata[EVT_NEST_BIT]));
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_stat & evt_mask);
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= RST_REG;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_IRQ_EN: reg_rdata <= irq_enable_reg;
        REG_EXT_EN2: reg_rdata <= {ONES_PAD, ext_enable_reg2};
        REG_IRQ_PRI: reg_rdata <= {1'b0, irq_priority_reg};
        REG_EXT_PRI2: reg_rdata <= {ONES_PAD, ext_priority_reg2};
        REG_EXT_CTRL: reg_rdata <= {2'b01, aux_group_enable, pend[0], pend[12], 3'b000};
        REG_PEND_LO: reg_rdata <= pend[8:1];
        REG_PEND_HI: reg_rdata <= {5'h00, pend[11:9]};
        REG_EXT_MODE: reg_rdata <= {6'h00, ext_edge_mode};
        REG_EVT_STAT: reg_rdata <= {6'h00, evt_stat};
        REG_EVT_MASK: reg_rdata <= {6'h00, evt_mask};
        REG_AUX_EN: reg_rdata <= aux_enable_reg;
        REG_ACTIVE: reg_rdata <= {offer_src, irq_req, act_aux, act_hi, act_lo};
        default: reg_rdata <= RST_REG;
      endcase
    end else begin
      reg_rdata <= RST_REG;
    end
  end

  assign below_src = (13'h0001 << offer_src) - 13'h0001;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);
  sequence s_offer_rise;
    $rose(irq_req);
  endsequence
  a_aux_vector_addr: assert property (irq_req && irq_level == LVL_AUX |->
    irq_vector == 8'h33)
    else $error("aux vector not at 0x33");
  a_wdt_vector_addr: assert property (irq_req && offer_src == SRC_WDT |->
    irq_vector == 8'h63)
    else $error("watchdog vector not at 0x63");
  a_vector_slot_align: assert property (irq_req |-> irq_vector[2:0] == 3'h3)
    else $error("vector off the eight byte grid");
  a_hi_natural_order: assert property (s_offer_rise ##0 irq_level == LVL_HI |->
    ({$past(hi_req), 1'b0} & below_src) == 13'h0000)
    else $error("high request skipped an earlier source");
  a_timer_flag_set: assert property (timer_ovf[0] |=> pend[SRC_T0])
    else $error("timer0 event did not set its flag");
  a_aux_no_sw_set: assert property (wr_ext_ctrl && !pend[0] && aux_evt == 8'h00 |=>
    !pend[0])
    else $error("software set the auxiliary flag");
  a_enable_gate: assert property (state == ST_IDLE && instr_done && req_en == '0 |=>
    !irq_req)
    else $error("request offered with nothing enabled");
  a_aux_level_fixed: assert property (irq_req |->
    (irq_level == LVL_AUX) == (offer_src == SRC_AUX))
    else $error("aux level mismatched with source");
  a_timer_ack_clear: assert property (ack_now && offer_src == SRC_T0 && !timer_ovf[0] |=>
    !pend[SRC_T0])
    else $error("timer0 flag survived vectoring");
  a_ext_level_follow: assert property (!ext_edge_mode[0] |=>
    pend[SRC_EXT0] == !$past(pin_q[0]))
    else $error("level mode flag not following pin");
  a_global_gate: assert property (s_offer_rise ##0 irq_level != LVL_AUX |->
    $past(global_irq_enable))
    else $error("vectored with global enable clear");
  a_instr_boundary: assert property (s_offer_rise |-> $past(instr_done))
    else $error("request raised between instructions");
  a_aux_no_preempt: assert property (s_offer_rise |-> !$past(act_aux))
    else $error("auxiliary handler preempted");
  a_lo_when_idle: assert property (s_offer_rise ##0 irq_level == LVL_LO |->
    !$past(act_aux) && !$past(act_hi) && !$past(act_lo))
    else $error("low request nested into a handler");

endmodule : irqv_top

//--- rtl/irqv_pkg.sv
package irqv_pkg;

  localparam int N_SRC = 13;
  localparam int SRC_W = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // natural polling order, 0 checked first
  localparam logic [3:0] SRC_AUX = 4'h0;
  localparam logic [3:0] SRC_EXT0 = 4'h1;
  localparam logic [3:0] SRC_T0 = 4'h2;
  localparam logic [3:0] SRC_EXT1 = 4'h3;
  localparam logic [3:0] SRC_T1 = 4'h4;
  localparam logic [3:0] SRC_SER0 = 4'h5;
  localparam logic [3:0] SRC_T2 = 4'h6;
  localparam logic [3:0] SRC_SER1 = 4'h7;
  localparam logic [3:0] SRC_WDT = 4'hc;

  // register offsets
  localparam logic [3:0] REG_IRQ_EN = 4'h0;
  localparam logic [3:0] REG_EXT_EN2 = 4'h1;
  localparam logic [3:0] REG_IRQ_PRI = 4'h2;
  localparam logic [3:0] REG_EXT_PRI2 = 4'h3;
  localparam logic [3:0] REG_EXT_CTRL = 4'h4;
  localparam logic [3:0] REG_PEND_LO = 4'h5;
  localparam logic [3:0] REG_PEND_HI = 4'h6;
  localparam logic [3:0] REG_EXT_MODE = 4'h7;
  localparam logic [3:0] REG_EVT_STAT = 4'h8;
  localparam logic [3:0] REG_EVT_MASK = 4'h9;
  localparam logic [3:0] REG_AUX_EN = 4'ha;
  localparam logic [3:0] REG_ACTIVE = 4'hb;

  // field positions
  localparam int GLOBAL_EN_BIT = 7;
  localparam int AUX_EN_BIT = 5;
  localparam int AUX_FLAG_BIT = 4;
  localparam int WDT_FLAG_BIT = 3;
  localparam int EVT_TAKEN_BIT = 0;
  localparam int EVT_NEST_BIT = 1;

  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [5:0] PIN_IDLE = 6'h3f;
  localparam logic [2:0] ONES_PAD = 3'h7;

  // vector table: base plus eight-byte slots
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam logic [7:0] VEC_STRIDE = 8'h08;
  localparam logic [7:0] VEC_AUX_SLOT = 8'h06;

  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LO = 2'b01,
    LVL_HI = 2'b10,
    LVL_AUX = 2'b11
  } irqv_lvl_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_OFFER = 1'b1
  } irqv_state_t;

  function automatic logic [7:0] irqv_vec_addr(input logic [3:0] src);
    logic [7:0] slot;
    if (src == SRC_AUX) begin
      slot = VEC_AUX_SLOT;
    end else if (src <= SRC_T2) begin
      slot = {4'h0, src} - 8'h01;
    end else begin
      slot = {4'h0, src};
    end
    return 8'(VEC_BASE + 8'(slot * VEC_STRIDE));
  endfunction : irqv_vec_addr

endpackage : irqv_pkg

//--- rtl/irqv_sync.sv
`timescale 1ns/1ps
module irqv_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  if (W < 1) begin : g_bad_width
    $error("irqv_sync width must be at least one");
  end

  // meta feeds only the second stage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : irqv_sync

//--- rtl/irqv_pick.sv
`timescale 1ns/1ps
module irqv_pick #(
  parameter int N = 12,
  parameter int IW = 4
) (
  input wire logic [N-1:0] req,
  output logic found,
  output logic [IW-1:0] idx
);
  if (N < 1 || N > (1 << IW)) begin : g_bad_size
    $error("irqv_pick index too narrow for request count");
  end

  // lowest index wins, matching the polling order
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = IW'(i);
      end
    end
  end
endmodule : irqv_pick

//--- dv/irqv_core_model.sv
`timescale 1ns/1ps
module irqv_core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire irqv_pkg::irqv_lvl_t irq_level,
  input wire logic run,
  input wire logic [3:0] ack_dly,
  input wire logic reti_req,
  output logic instr_done,
  output logic vector_ack,
  output logic reti_done,
  output logic [7:0] last_vec,
  output irqv_pkg::irqv_lvl_t last_lvl,
  output logic [7:0] n_taken
);
  import irqv_pkg::*;
  logic [3:0] wait_cnt;
  // one instruction per cycle, the densest evaluation rate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instr_done <= 1'b0;
      reti_done <= 1'b0;
    end else begin
      instr_done <= run;
      reti_done <= reti_req;
    end
  end
  // a slow core lets the offer stand ack_dly + 1 cycles before raising vector_ack
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vector_ack <= 1'b0;
      wait_cnt <= 4'h0;
      last_vec <= 8'h00;
      last_lvl <= LVL_NONE;
      n_taken <= 8'h00;
    end else if (vector_ack || !irq_req) begin
      vector_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt == ack_dly) begin
      vector_ack <= 1'b1;
      last_vec <= irq_vector;
      last_lvl <= irq_level;
      n_taken <= n_taken + 8'h01;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : irqv_core_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import irqv_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [5:0] ext_pin_n = 6'h3f;
  logic [2:0] timer_ovf = 3'h0;
  logic [1:0] serial0_evt = 2'h0;
  logic [1:0] serial1_evt = 2'h0;
  logic watchdog_evt = 1'b0;
  logic [7:0] aux_evt = 8'h00;
  logic instr_done, vector_ack, reti_done, irq_req, irq_out;
  logic [7:0] irq_vector, last_vec, n_taken, d;
  irqv_lvl_t irq_level, last_lvl;
  logic run = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic reti_req = 1'b0;
  logic [7:0] seen = 8'h00;
  int errors = 0;
  int n_tests = 0;

  always #20 mclk = ~mclk;

  irqv_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_pin_n(ext_pin_n),
    .timer_ovf(timer_ovf), .serial0_evt(serial0_evt), .serial1_evt(serial1_evt),
    .watchdog_evt(watchdog_evt), .aux_evt(aux_evt), .instr_done(instr_done),
    .vector_ack(vector_ack), .reti_done(reti_done), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level), .irq_out(irq_out));

  irqv_core_model core (.mclk(mclk), .rst_n(rst_n), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level), .run(run), .ack_dly(ack_dly),
    .reti_req(reti_req), .instr_done(instr_done), .vector_ack(vector_ack),
    .reti_done(reti_done), .last_vec(last_vec), .last_lvl(last_lvl), .n_taken(n_taken));

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task final_report();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  task do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    run <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    seen = 8'h00;
    repeat (3) @(posedge mclk);
    run <= 1'b1;
  endtask : do_reset

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task pulse(input logic [2:0] t, input logic [7:0] a);
    @(posedge mclk);
    timer_ovf <= t;
    aux_evt <= a;
    @(posedge mclk);
    timer_ovf <= 3'h0;
    aux_evt <= 8'h00;
  endtask : pulse

  task reti();
    @(posedge mclk);
    reti_req <= 1'b1;
    @(posedge mclk);
    reti_req <= 1'b0;
  endtask : reti

  task wait_take(input logic [7:0] vec, input irqv_lvl_t lvl);
    for (int k = 0; k < 60 && n_taken === seen; k++) @(posedge mclk);
    chk(n_taken, seen + 8'h01);
    seen = n_taken;
    chk(last_vec, vec);
    chk({6'h0, last_lvl}, {6'h0, lvl});
  endtask : wait_take

  task no_take();
    repeat (20) @(posedge mclk);
    chk(n_taken, seen);
  endtask : no_take

  task t_reset();
    do_reset();
    chk({7'h0, irq_req}, 8'h00);
    rd(REG_IRQ_EN);
    chk(d, 8'h00);
    rd(REG_EXT_EN2);
    chk(d, 8'he0);
    rd(REG_EXT_CTRL);
    chk(d, 8'h40);
    wr(REG_EXT_PRI2, 8'h15);
    rd(REG_EXT_PRI2);
    chk(d, 8'hf5);
    rd(4'hf);
    chk(d, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task t_gate();
    do_reset();
    pulse(3'h2, 8'h00);
    rd(REG_PEND_LO);
    chk(d, 8'h08);
    wr(REG_IRQ_EN, 8'h08);
    no_take();
    wr(REG_IRQ_EN, 8'h80);
    no_take();
    wr(REG_IRQ_EN, 8'h88);
    wait_take(8'h1b, LVL_LO);
    rd(REG_PEND_LO);
    chk(d, 8'h00);
    chk({7'h0, irq_out}, 8'h00);
    reti();
    @(posedge mclk);
    ext_pin_n <= 6'h3e;
    repeat (6) @(posedge mclk);
    wr(REG_IRQ_EN, 8'h81);
    wait_take(8'h03, LVL_LO);
    rd(REG_PEND_LO);
    chk(d, 8'h01);
    @(posedge mclk);
    ext_pin_n <= 6'h3f;
    repeat (6) @(posedge mclk);
    rd(REG_PEND_LO);
    chk(d, 8'h00);
    reti();
    @(posedge mclk);
    serial0_evt <= 2'h2;
    serial1_evt <= 2'h1;
    watchdog_evt <= 1'b1;
    @(posedge mclk);
    serial0_evt <= 2'h0;
    serial1_evt <= 2'h0;
    watchdog_evt <= 1'b0;
    rd(REG_PEND_LO);
    chk(d, 8'h50);
    rd(REG_EXT_CTRL);
    chk(d, 8'h48);
    wr(REG_EXT_MODE, 8'h02);
    @(posedge mclk);
    ext_pin_n <= 6'h39;
    repeat (6) @(posedge mclk);
    ext_pin_n <= 6'h3f;
    repeat (6) @(posedge mclk);
    rd(REG_PEND_LO);
    chk(d, 8'hd4);
    $display("test gating done");
  endtask : t_gate

  // all twelve flags set by software in three register writes, then served one by one
  task t_order();
    logic [7:0] lo;
    logic [2:0] hi;
    logic wd;
    lo = 8'hff;
    hi = 3'h7;
    wd = 1'b1;
    do_reset();
    wr(REG_EXT_MODE, 8'h03);
    wr(REG_IRQ_EN, 8'h7f);
    wr(REG_EXT_EN2, 8'h1f);
    wr(REG_PEND_LO, lo);
    wr(REG_PEND_HI, 8'h07);
    wr(REG_EXT_CTRL, 8'h08);
    wr(REG_IRQ_EN, 8'hff);
    for (int i = 1; i <= 12; i++) begin
      wait_take(8'(3 + 8 * (i < 7 ? i - 1 : i)), LVL_LO);
      if (i <= 8) begin
        rd(REG_PEND_LO);
        chk({7'h0, d[i-1]}, (i > 4) ? 8'h01 : 8'h00);
        lo[i-1] = 1'b0;
      end else if (i <= 11) begin
        hi[i-9] = 1'b0;
      end else begin
        wd = 1'b0;
      end
      wr(REG_PEND_LO, lo);
      wr(REG_PEND_HI, {5'h0, hi});
      wr(REG_EXT_CTRL, {4'h0, wd, 3'h0});
      reti();
    end
    no_take();
    $display("test order done");
  endtask : t_order

  task t_prio();
    do_reset();
    ack_dly <= 4'h3;
    wr(REG_EVT_MASK, 8'h03);
    wr(REG_IRQ_PRI, 8'h20);
    wr(REG_IRQ_EN, 8'ha2);
    wr(REG_AUX_EN, 8'h01);
    wr(REG_EXT_CTRL, 8'h20);
    pulse(3'h1, 8'h00);
    wait_take(8'h0b, LVL_LO);
    pulse(3'h4, 8'h00);
    wait_take(8'h2b, LVL_HI);
    wr(REG_EVT_STAT, 8'h03);
    pulse(3'h0, 8'h01);
    rd(REG_EXT_CTRL);
    chk(d, 8'h70);
    wait_take(8'h33, LVL_AUX);
    repeat (2) @(posedge mclk);
    chk({7'h0, irq_out}, 8'h01);
    rd(REG_ACTIVE);
    chk(d, 8'h07);
    rd(REG_EVT_STAT);
    chk(d, 8'h03);
    wr(REG_EVT_STAT, 8'h03);
    repeat (3) @(posedge mclk);
    chk({7'h0, irq_out}, 8'h00);
    no_take();
    wr(REG_EXT_CTRL, 8'h20);
    wr(REG_EXT_CTRL, 8'h30);
    rd(REG_EXT_CTRL);
    chk(d, 8'h60);
    reti();
    no_take();
    wr(REG_PEND_LO, 8'h00);
    reti();
    reti();
    wr(REG_EXT_CTRL, 8'h00);
    pulse(3'h0, 8'h01);
    rd(REG_EXT_CTRL);
    chk(d, 8'h50);
    no_take();
    $display("test priority done");
  endtask : t_prio

  initial begin
    t_reset();
    t_gate();
    t_order();
    t_prio();
    final_report();
  end

  // the tests need about 500 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    final_report();
  end
endmodule : tb_top
